// ===== logic/seq_cfg_pkg.sv
// Package with the sequencer configuration map, field layout and carriers
package seq_cfg_pkg;

   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 11;

   // Register addresses on the serial control port
   localparam logic [ADDR_W-1:0] OFS_GENERAL = 9'h0c0;
   localparam logic [ADDR_W-1:0] OFS_LINE_DELAY = 9'h0c1;
   localparam logic [ADDR_W-1:0] OFS_KNEE = 9'h0c2;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 9'h0c3;
   localparam logic [ADDR_W-1:0] OFS_SPARE = 9'h0c4;
   localparam logic [ADDR_W-1:0] OFS_DARK = 9'h0c5;
   localparam logic [ADDR_W-1:0] OFS_PADDING = 9'h0c6;
   localparam logic [ADDR_W-1:0] OFS_TICK = 9'h0c7;
   localparam logic [ADDR_W-1:0] OFS_FRAME = 9'h0c8;
   localparam logic [ADDR_W-1:0] OFS_INTEG = 9'h0c9;
   localparam logic [ADDR_W-1:0] OFS_KNEE_TIME = 9'h0ca;

   // Word indices inside the bank
   localparam int IDX_GENERAL = 0;
   localparam int IDX_LINE_DELAY = 1;
   localparam int IDX_KNEE = 2;
   localparam int IDX_WINDOW = 3;
   localparam int IDX_SPARE = 4;
   localparam int IDX_DARK = 5;
   localparam int IDX_PADDING = 6;
   localparam int IDX_TICK = 7;
   localparam int IDX_FRAME = 8;
   localparam int IDX_INTEG = 9;
   localparam int IDX_KNEE_TIME = 10;

   // Values after reset, by index
   localparam logic [DATA_W-1:0] RESET_VALUES [NUM_REGS] = '{
      16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h0000, 16'h0102,
      16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};

   // Writable bits, by index; reserved bits stay zero
   localparam logic [DATA_W-1:0] WRITE_MASKS [NUM_REGS] = '{
      16'h3df3, 16'hffff, 16'h0007, 16'h00ff, 16'h0000, 16'h01ff,
      16'h0fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

   // General setup fields
   localparam int GEN_ENABLE_BIT = 0;
   localparam int GEN_ROLLING_BIT = 1;
   localparam int GEN_TRIGGERED_BIT = 4;
   localparam int GEN_SLAVE_BIT = 5;
   localparam int GEN_DELAY_EN_BIT = 6;
   localparam int GEN_SUBSAMPLE_BIT = 7;
   localparam int GEN_BINNING_BIT = 8;
   localparam int GEN_WINDOW_STATS_BIT = 10;
   localparam int GEN_MONITOR_LSB = 11;
   localparam int MONITOR_W = 3;

   // Line delay fields
   localparam int LINE_EXT_LSB = 0;
   localparam int POST_DELAY_LSB = 8;
   localparam int BYTE_W = 8;

   // Integration knee fields
   localparam int KNEE_DUAL_BIT = 0;
   localparam int KNEE_TRIPLE_BIT = 1;
   localparam int KNEE_FRAME_PERIOD_INTERPRETATION_BIT = 2;

   // Dark and padding row fields
   localparam int DARK_ROWS_LSB = 0;
   localparam int BLANK_FIRST_BIT = 8;
   localparam logic [BYTE_W-1:0] DARK_ROWS_MIN = 8'h01;
   localparam int PADDING_W = 12;

   // Divider value taken when software programs zero
   localparam logic [DATA_W-1:0] TICK_DIV_MIN = 16'h0001;

   typedef struct packed {
      logic sequencer_enable;
      logic rolling_shutter;
      logic triggered_mode;
      logic slave_mode;
      logic subsampling;
      logic binning;
      logic window_stats_only;
      logic [MONITOR_W-1:0] monitor_select;
      logic [BYTE_W-1:0] line_readout_extension;
      logic post_delay_active;
      logic [BYTE_W-1:0] post_overhead_delay;
      logic dual_slope_active;
      logic triple_slope_active;
      logic frame_period_interpretation;
      logic [BYTE_W-1:0] window_select_mask;
      logic [BYTE_W-1:0] dark_row_count;
      logic blank_first_row;
      logic [PADDING_W-1:0] padding_row_count;
      logic [DATA_W-1:0] exposure_tick_divider;
      logic [DATA_W-1:0] frame_period_count;
      logic frame_period_is_reset;
      logic [DATA_W-1:0] integration_time;
      logic integration_in_lines;
      logic [DATA_W-1:0] second_knee_exposure;
   } settings_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
      logic read;
   } reg_req_s;

endpackage : seq_cfg_pkg

// ===== logic/config_word.sv
// One configuration word with reset value and write mask
`timescale 1ns/100ps
module config_word
   import seq_cfg_pkg::*;
#(
   parameter logic [DATA_W-1:0] RESET_VALUE = 16'h0000,
   parameter logic [DATA_W-1:0] WRITE_MASK = 16'hffff
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0] value
);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         value <= RESET_VALUE;
      end else if (wr_en) begin
         value <= wr_data & WRITE_MASK;
      end
   end

endmodule : config_word

// ===== logic/sensor_sequencer_timing_config.sv
// Sequencer timing configuration bank with settings hand-off
`timescale 1ns/100ps
module sensor_sequencer_timing_config
   import seq_cfg_pkg::*;
#(
   parameter int MON_PINS = 2,
   parameter int MON_CHOICES = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [MON_CHOICES-1:0][MON_PINS-1:0] monitor_sources,
   output logic [MON_PINS-1:0] monitor_pins,
   output settings_s settings,
   output logic exposure_tick
);

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   reg_req_s req;
   logic [NUM_REGS-1:0] hit;
   logic [NUM_REGS-1:0] wr_sel;
   logic [DATA_W-1:0] words [NUM_REGS];
   logic any_hit;

   assign req.addr = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.write = reg_write;
   assign req.read = reg_read;

   always_comb begin
      hit = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         hit[i] = (req.addr == OFS_GENERAL + ADDR_W'(i));
      end
   end

   assign any_hit = |hit;
   assign wr_sel = hit & {NUM_REGS{req.write}};

   ////////////////////////////////////////////////////////////////////////
   // Register words

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : gen_word
         config_word #(
            .RESET_VALUE(RESET_VALUES[g]),
            .WRITE_MASK(WRITE_MASKS[g])
         ) u_word (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .wr_en(wr_sel[g]),
            .wr_data(req.wdata),
            .value(words[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Field views

   logic [DATA_W-1:0] w_gen;
   logic [DATA_W-1:0] w_line;
   logic [DATA_W-1:0] w_knee;
   logic [DATA_W-1:0] w_win;
   logic [DATA_W-1:0] w_dark;
   logic [DATA_W-1:0] w_pad;
   logic rolling;
   logic delay_enable;
   logic [MONITOR_W-1:0] mon_sel;
   logic [BYTE_W-1:0] line_ext;
   logic [BYTE_W-1:0] post_delay;
   logic [BYTE_W-1:0] dark_raw;
   logic [DATA_W-1:0] tick_div_eff;

   assign w_gen = words[IDX_GENERAL];
   assign w_line = words[IDX_LINE_DELAY];
   assign w_knee = words[IDX_KNEE];
   assign w_win = words[IDX_WINDOW];
   assign w_dark = words[IDX_DARK];
   assign w_pad = words[IDX_PADDING];

   assign rolling = w_gen[GEN_ROLLING_BIT];
   assign delay_enable = w_gen[GEN_DELAY_EN_BIT];
   assign mon_sel = w_gen[GEN_MONITOR_LSB +: MONITOR_W];
   assign line_ext = w_line[LINE_EXT_LSB +: BYTE_W];
   assign post_delay = w_line[POST_DELAY_LSB +: BYTE_W];
   assign dark_raw = w_dark[DARK_ROWS_LSB +: BYTE_W];

   // A zero divider would stall the tick; treat it as one clock
   assign tick_div_eff = (words[IDX_TICK] == '0) ? TICK_DIV_MIN
      : words[IDX_TICK];

   ////////////////////////////////////////////////////////////////////////
   // Settings handed to the sequencer

   settings_s next_settings;

   always_comb begin
      next_settings = '0;
      next_settings.sequencer_enable = w_gen[GEN_ENABLE_BIT];
      next_settings.rolling_shutter = rolling;
      next_settings.triggered_mode = w_gen[GEN_TRIGGERED_BIT] & ~rolling;
      next_settings.slave_mode = w_gen[GEN_SLAVE_BIT] & ~rolling;
      next_settings.subsampling = w_gen[GEN_SUBSAMPLE_BIT];
      next_settings.binning = w_gen[GEN_BINNING_BIT];
      next_settings.window_stats_only =
         w_gen[GEN_WINDOW_STATS_BIT];
      next_settings.monitor_select = mon_sel;

      // Line extension only stretches rolling shutter lines
      next_settings.line_readout_extension =
         rolling ? line_ext : '0;

      // Post overhead delay is zero unless enabled
      next_settings.post_delay_active = delay_enable;
      next_settings.post_overhead_delay =
         delay_enable ? post_delay : '0;

      // Slope knees are global shutter features
      next_settings.dual_slope_active =
         w_knee[KNEE_DUAL_BIT] & ~rolling;
      next_settings.triple_slope_active =
         w_knee[KNEE_TRIPLE_BIT] & ~rolling;
      next_settings.frame_period_interpretation =
         w_knee[KNEE_FRAME_PERIOD_INTERPRETATION_BIT];

      next_settings.window_select_mask = w_win[BYTE_W-1:0];

      // Illegal zero dark row count is held at the minimum
      next_settings.dark_row_count = (dark_raw < DARK_ROWS_MIN)
         ? DARK_ROWS_MIN : dark_raw;
      next_settings.blank_first_row = w_dark[BLANK_FIRST_BIT];

      next_settings.padding_row_count =
         rolling ? w_pad[PADDING_W-1:0] : '0;

      next_settings.exposure_tick_divider = tick_div_eff;

      // Frame period is only meaningful in global shutter
      next_settings.frame_period_count =
         rolling ? '0 : words[IDX_FRAME];
      next_settings.frame_period_is_reset =
         ~rolling & ~w_knee[KNEE_FRAME_PERIOD_INTERPRETATION_BIT];

      next_settings.integration_time = words[IDX_INTEG];
      next_settings.integration_in_lines = rolling;

      next_settings.second_knee_exposure =
         rolling ? '0 : words[IDX_KNEE_TIME];
   end

   // Settings flops, one block per register concern
   logic seq_enable, shutter_rolling, trig_mode, slave_sel, subsample_on;
   logic binning_on, stats_window_only, delay_on, dual_on, triple_on;
   logic period_interp, blank_first, period_is_reset, exposure_in_lines;
   logic [MONITOR_W-1:0] monitor_choice;
   logic [BYTE_W-1:0] extension_pixels, delay_cycles, window_mask, dark_rows;
   logic [PADDING_W-1:0] padding_rows;
   logic [DATA_W-1:0] tick_divider, period_count, exposure_count;
   logic [DATA_W-1:0] knee_exposure;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         seq_enable <= 1'b0;
         shutter_rolling <= 1'b0;
         trig_mode <= 1'b0;
         slave_sel <= 1'b0;
         subsample_on <= 1'b0;
         binning_on <= 1'b0;
         stats_window_only <= 1'b0;
         monitor_choice <= '0;
      end else begin
         seq_enable <= next_settings.sequencer_enable;
         shutter_rolling <= next_settings.rolling_shutter;
         trig_mode <= next_settings.triggered_mode;
         slave_sel <= next_settings.slave_mode;
         subsample_on <= next_settings.subsampling;
         binning_on <= next_settings.binning;
         stats_window_only <= next_settings.window_stats_only;
         monitor_choice <= next_settings.monitor_select;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         extension_pixels <= '0;
         delay_on <= 1'b0;
         delay_cycles <= '0;
      end else begin
         extension_pixels <= next_settings.line_readout_extension;
         delay_on <= next_settings.post_delay_active;
         delay_cycles <= next_settings.post_overhead_delay;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dual_on <= 1'b0;
         triple_on <= 1'b0;
         period_interp <= 1'b0;
      end else begin
         dual_on <= next_settings.dual_slope_active;
         triple_on <= next_settings.triple_slope_active;
         period_interp <= next_settings.frame_period_interpretation;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         window_mask <= '0;
         dark_rows <= '0;
         blank_first <= 1'b0;
         padding_rows <= '0;
      end else begin
         window_mask <= next_settings.window_select_mask;
         dark_rows <= next_settings.dark_row_count;
         blank_first <= next_settings.blank_first_row;
         padding_rows <= next_settings.padding_row_count;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_divider <= '0;
         period_count <= '0;
         period_is_reset <= 1'b0;
         exposure_count <= '0;
         exposure_in_lines <= 1'b0;
         knee_exposure <= '0;
      end else begin
         tick_divider <= next_settings.exposure_tick_divider;
         period_count <= next_settings.frame_period_count;
         period_is_reset <= next_settings.frame_period_is_reset;
         exposure_count <= next_settings.integration_time;
         exposure_in_lines <= next_settings.integration_in_lines;
         knee_exposure <= next_settings.second_knee_exposure;
      end
   end

   assign settings = {seq_enable, shutter_rolling, trig_mode, slave_sel,
      subsample_on, binning_on, stats_window_only, monitor_choice,
      extension_pixels, delay_on, delay_cycles, dual_on, triple_on,
      period_interp, window_mask, dark_rows, blank_first, padding_rows,
      tick_divider, period_count, period_is_reset, exposure_count,
      exposure_in_lines, knee_exposure};

   ////////////////////////////////////////////////////////////////////////
   // Exposure tick generator

   logic [DATA_W-1:0] tick_count;
   logic tick_wrap;

   assign tick_wrap = (tick_count >= tick_div_eff - TICK_DIV_MIN);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_count <= '0;
      end else if (rolling || tick_wrap) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + TICK_DIV_MIN;
      end
   end

   // One pulse every divider clocks, global shutter only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         exposure_tick <= 1'b0;
      end else begin
         exposure_tick <= ~rolling & tick_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Monitor pins

   logic [MON_PINS-1:0] next_monitor;

   always_comb begin
      next_monitor = '0;
      if (int'(mon_sel) < MON_CHOICES) begin
         next_monitor = monitor_sources[mon_sel];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         monitor_pins <= '0;
      end else begin
         monitor_pins <= next_monitor;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i]) begin
            next_rdata = words[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (req.read) begin
         reg_rdata <= any_hit ? next_rdata : '0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= req.read;
      end
   end

endmodule : sensor_sequencer_timing_config

// ===== sim/seq_cfg_checker_properties.sv
// Port checker of the sequencer configuration bank
`timescale 1ns/100ps
module seq_cfg_checker
   import seq_cfg_pkg::*;
#(
   parameter int MON_PINS = 2,
   parameter int MON_CHOICES = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [MON_CHOICES-1:0][MON_PINS-1:0] monitor_sources,
   input wire logic [MON_PINS-1:0] monitor_pins,
   input wire settings_s settings,
   input wire logic exposure_tick
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [MON_CHOICES-1:0][MON_PINS-1:0] src_q;
   always_ff @(posedge clk_sys) begin
      src_q <= monitor_sources;
   end
   logic div3;
   assign div3 = (settings.exposure_tick_divider == 16'h0003);
   ////////////////////////////////////////////////////////////////////////
   property p_rvalid; $past(resetn) |-> reg_rvalid == $past(reg_read);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("rvalid timing");
   property p_spare; reg_read && reg_addr == OFS_SPARE |=> reg_rdata == 0;
   endproperty
   a_spare: assert property (p_spare) else $error("spare not zero");
   property p_mon;
      $past(resetn) |-> monitor_pins == src_q[settings.monitor_select];
   endproperty
   a_mon: assert property (p_mon) else $error("monitor pins");
   property p_post;
      !settings.post_delay_active |-> settings.post_overhead_delay == '0;
   endproperty
   a_post: assert property (p_post) else $error("post delay");
   property p_slope; settings.rolling_shutter |-> !settings.dual_slope_active
      && !settings.triple_slope_active; endproperty
   a_slope: assert property (p_slope) else $error("rolling knee");
   property p_pad;
      !settings.rolling_shutter |-> settings.padding_row_count == '0;
   endproperty
   a_pad: assert property (p_pad) else $error("padding in global");
   property p_dark; $past(resetn) |-> settings.dark_row_count != 8'h00;
   endproperty
   a_dark: assert property (p_dark) else $error("dark rows zero");
   property p_tick; exposure_tick && div3 ##1 div3 [*3] |->
      exposure_tick && !$past(exposure_tick) && !$past(exposure_tick, 2);
   endproperty
   a_tick: assert property (p_tick) else $error("tick spacing");
   c_spare: cover property (reg_read && reg_addr == OFS_SPARE);
   c_tick: cover property (exposure_tick);
   c_roll: cover property (settings.rolling_shutter
      && settings.post_delay_active);
endmodule : seq_cfg_checker

bind sensor_sequencer_timing_config seq_cfg_checker #(.MON_PINS(MON_PINS),
   .MON_CHOICES(MON_CHOICES)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .monitor_sources(monitor_sources), .monitor_pins(monitor_pins),
   .settings(settings), .exposure_tick(exposure_tick));

// ===== sim/sensor_sequencer_timing_config_tb.sv
// Self-checking bench of the sequencer configuration bank
`timescale 1ns/100ps
module sensor_sequencer_timing_config_tb import seq_cfg_pkg::*;;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0][1:0] monitor_sources = '0;
   logic [1:0] monitor_pins;
   settings_s settings;
   logic exposure_tick;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'h00000024;
   int errors = 0;
   int n_compared = 0;
   always #4 clk_sys = ~clk_sys;
   sensor_sequencer_timing_config u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .monitor_sources(monitor_sources), .monitor_pins(monitor_pins),
      .settings(settings), .exposure_tick(exposure_tick));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t read %h want %h", $time, got, exp);
      end
   endtask : cmp_rd
   task automatic cmp_set(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t setting %h want %h", $time, got, exp);
      end
   endtask : cmp_set
   task automatic acc(input logic w, logic [8:0] a, logic [15:0] d);
      @(negedge clk_sys);
      reg_write = w;
      reg_read = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_write = 1'b0;
      reg_read = 1'b0;
   endtask : acc
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 16'h0000);
   endtask : rd
   task automatic do_reset();
      resetn = 1'b0;
      repeat (5) @(negedge clk_sys);
      resetn = 1'b1;
   endtask : do_reset
   task automatic chk_defaults();
      for (int i = 0; i < NUM_REGS; i++) begin
         rd(OFS_GENERAL + 9'(i), RESET_VALUES[i]);
      end
      rd(9'h0cb, 16'h0000);
      cmp_set(16'(settings.dark_row_count), 16'h0002);
      cmp_set(16'(settings.blank_first_row), 16'h0001);
      cmp_set(16'(settings.frame_period_interpretation), 16'h0001);
      cmp_set(16'(settings.window_select_mask), 16'h0001);
      cmp_set(settings.exposure_tick_divider, 16'h0001);
      $display("test defaults done");
   endtask : chk_defaults
   task automatic count_ticks(output int n);
      n = 0;
      repeat (30) begin
         @(posedge clk_sys);
         if (exposure_tick === 1'b1) n++;
      end
   endtask : count_ticks
   task automatic complete_run();
      if (exp_q.size() != 0) begin
         errors++;
         $display("[ERR] %0t reads left unanswered", $time);
      end
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk_sys) begin
      monitor_sources <= 16'(rnd());
   end
   always @(posedge clk_sys) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("[ERR] %0t unexpected read", $time);
         end else begin
            cmp_rd(reg_rdata, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      logic [15:0] d;
      int n;
      do_reset();
      chk_defaults();
      for (int i = 0; i < NUM_REGS; i++) begin
         d = 16'(rnd());
         acc(1'b1, OFS_GENERAL + 9'(i), d);
         rd(OFS_GENERAL + 9'(i), d & WRITE_MASKS[i]);
      end
      $display("test masks done");
      repeat (2) @(negedge clk_sys);
      do_reset();
      chk_defaults();
      acc(1'b1, OFS_GENERAL, 16'h3c73);
      acc(1'b1, OFS_LINE_DELAY, 16'ha55a);
      acc(1'b1, OFS_PADDING, 16'h0fff);
      acc(1'b1, OFS_KNEE, 16'h0003);
      acc(1'b1, OFS_TICK, 16'h0003);
      @(negedge clk_sys);
      cmp_set(16'(settings.line_readout_extension), 16'h005a);
      cmp_set(16'(settings.post_overhead_delay), 16'h00a5);
      cmp_set(16'(settings.window_stats_only), 16'h0001);
      cmp_set(16'(settings.monitor_select), 16'h0007);
      cmp_set(16'(settings.rolling_shutter), 16'h0001);
      cmp_set(16'(settings.padding_row_count), 16'h0fff);
      cmp_set(16'(settings.integration_in_lines), 16'h0001);
      cmp_set(16'(settings.triggered_mode), 16'h0000);
      cmp_set(16'(settings.slave_mode), 16'h0000);
      cmp_set(16'(settings.post_delay_active), 16'h0001);
      cmp_set(16'(monitor_pins), 16'(monitor_sources[7]));
      count_ticks(n);
      cmp_set(16'(n), 16'h0000);
      $display("test rolling done");
      acc(1'b1, OFS_GENERAL, 16'h01b0);
      acc(1'b1, OFS_DARK, 16'h0000);
      acc(1'b1, OFS_FRAME, 16'h1234);
      acc(1'b1, OFS_KNEE_TIME, 16'h9abc);
      acc(1'b1, OFS_INTEG, 16'h5678);
      @(negedge clk_sys);
      cmp_set(16'(settings.window_stats_only), 16'h0000);
      cmp_set(16'(settings.post_overhead_delay), 16'h0000);
      cmp_set(16'(settings.line_readout_extension), 16'h0000);
      cmp_set(16'(settings.dual_slope_active), 16'h0001);
      cmp_set(16'(settings.triple_slope_active), 16'h0001);
      cmp_set(16'(settings.frame_period_is_reset), 16'h0001);
      cmp_set(16'(settings.dark_row_count), 16'h0001);
      cmp_set(16'(settings.blank_first_row), 16'h0000);
      cmp_set(settings.frame_period_count, 16'h1234);
      cmp_set(settings.second_knee_exposure, 16'h9abc);
      cmp_set(settings.integration_time, 16'h5678);
      cmp_set(16'(settings.padding_row_count), 16'h0000);
      cmp_set(16'(settings.triggered_mode), 16'h0001);
      cmp_set(16'(settings.slave_mode), 16'h0001);
      cmp_set(16'(settings.post_delay_active), 16'h0000);
      cmp_set(settings.exposure_tick_divider, 16'h0003);
      cmp_set(16'(monitor_pins), 16'(monitor_sources[0]));
      count_ticks(n);
      cmp_set(16'(n), 16'h000a);
      acc(1'b1, OFS_TICK, 16'h0000);
      @(negedge clk_sys);
      cmp_set(settings.exposure_tick_divider, 16'h0001);
      count_ticks(n);
      cmp_set(16'(n), 16'h001e);
      $display("test global done");
      repeat (3) @(negedge clk_sys);
      complete_run();
   end
endmodule : sensor_sequencer_timing_config_tb
